// File: design/ubrx_defines.svh
/*
 * Constants of the baud generator and asynchronous receiver:
 * register addresses, bit positions, reset values and clock figures.
 * Assumes inclusion by the package and the design file only.
 */
`ifndef UBRX_DEFINES_SVH
`define UBRX_DEFINES_SVH

`define UBRX_ADDR_RCV_STAT 8'h13
`define UBRX_ADDR_RCV_BYTE 8'h14
`define UBRX_ADDR_XMT_STAT 8'h15
`define UBRX_ADDR_PERIPH_FLAGS 8'h16
`define UBRX_ADDR_DIVISOR 8'h17
`define UBRX_ADDR_INT_ENABLES 8'h18

`define UBRX_BIT_PORT_EN 7
`define UBRX_BIT_NINE_SEL 6
`define UBRX_BIT_SINGLE_EN 5
`define UBRX_BIT_CONT_EN 4
`define UBRX_BIT_FRAME_ERR 2
`define UBRX_BIT_OVERRUN 1
`define UBRX_BIT_NINTH 0
`define UBRX_BIT_SYNC 4
`define UBRX_BIT_MASTER 7
`define UBRX_BIT_RCV_FLAG 0
`define UBRX_BIT_XMT_FLAG 1
`define UBRX_BIT_RCV_IE 0

`define UBRX_RST_PERIPH_FLAGS 8'h02
`define UBRX_RST_XMT_STAT 8'h02
`define UBRX_RST_ZERO 8'h00
`define UBRX_RST_FLAGS_UPPER 7'h01

`define UBRX_ASYNC_PRESCALE 6'h03
`define UBRX_SYNC_PRESCALE 6'h00
`define UBRX_OVS_LAST 4'hF
`define UBRX_VOTE_FIRST 4'h6
`define UBRX_VOTE_MID 4'h7
`define UBRX_VOTE_LAST 4'h8
`define UBRX_DATA_BITS 4'h8
`define UBRX_NINE_BITS 4'h9

`endif

// File: design/ubrx_pkg.sv
/*
 * Types shared by the receiver design.
 * Assumes ubrx_defines.svh is on the include path.
 */
package ubrx_pkg;
  `include "ubrx_defines.svh"

  typedef enum logic [1:0] {
    UBRX_IDLE = 2'b00,
    UBRX_START = 2'b01,
    UBRX_DATA = 2'b10,
    UBRX_STOP = 2'b11
  } ubrx_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ubrx_bus_s;

  typedef struct packed {
    logic ninth;
    logic frame_err;
    logic [7:0] data;
  } ubrx_char_s;
endpackage : ubrx_pkg

// File: design/ubrx_receiver.sv
/*
 * Baud rate generator and asynchronous receiver with a two-deep FIFO,
 * overrun and framing detection and a receive interrupt request.
 * Assumes a register master on mclk_i and a receive pin from outside.
 */
// Overview of operation
// - a free-running 8-bit baud timer is reloaded from the divisor register
// - async rate is clock/(64(X+1)), sync rate is clock/(X+1), X 0..255
// - formulas apply only to async and sync master with internal clock
// - writing the divisor loads the baud timer with the written value at once
// - async reception runs only while continuous-receive enable is set
// - pin is oversampled at sixteen times the bit rate; shifter steps per bit
// - after the stop bit the character enters the FIFO and sets the flag
// - interrupt request is flag AND enable
// - receive flag is read only; cleared once the FIFO is empty
// - data register is a two-entry FIFO read in arrival order
// - full FIFO at a further stop bit sets overrun and drops the character
// - while overrun is set no character enters the FIFO
// - overrun clears only when the receive logic is reset by its enable
// - framing error flags a character whose stop bit samples low
// - framing flag and ninth bit travel with each character in the FIFO
// - each bit is a majority of samples at oversample ticks seven to nine
// - the oversample clock runs freely; samples recur every sixteen ticks
// - with nine-bit select a ninth bit is received and shown in status
// - clearing both receive enables or port enable resets the receive logic
`timescale 1ns/1ns

module ubrx_receiver
  import ubrx_pkg::*;
(
  input wire logic mclk_i, // 100 MHz system clock
  input wire logic resetn_i, // asynchronous reset, active low
  input wire logic clk_en_i, // freezes all state while low
  input wire logic [7:0] reg_addr_i, // register address
  input wire logic [7:0] reg_wdata_i, // register write data
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  output logic [7:0] reg_rdata_o, // read data, cycle after strobe
  input wire logic receive_line_pin_i, // serial receive pin
  output logic rcv_irq_o // receive interrupt request
);

  // ----------------------------------------------------------------
  // bus and pin capture
  // ----------------------------------------------------------------
  ubrx_bus_s bus;
  assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  logic pin_meta_reg;
  logic pin_sync_reg;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
    end else if (clk_en_i) begin
      pin_meta_reg <= receive_line_pin_i;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic port_enable_reg;
  logic nine_bit_select_reg;
  logic single_receive_enable_reg;
  logic continuous_receive_enable_reg;
  logic [7:0] xmt_stat_reg;
  logic [7:0] baud_divisor_reg;
  logic receive_int_enable_reg;
  logic [7:0] int_enables_upper_reg;
  logic [6:0] flags_upper_reg;

  logic wr_stat;
  logic wr_div;
  assign wr_stat = bus.wr && (bus.addr == `UBRX_ADDR_RCV_STAT);
  assign wr_div = bus.wr && (bus.addr == `UBRX_ADDR_DIVISOR);

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_enable_reg <= 1'b0;
      nine_bit_select_reg <= 1'b0;
      single_receive_enable_reg <= 1'b0;
      continuous_receive_enable_reg <= 1'b0;
      xmt_stat_reg <= `UBRX_RST_XMT_STAT;
      baud_divisor_reg <= `UBRX_RST_ZERO;
      receive_int_enable_reg <= 1'b0;
      int_enables_upper_reg <= `UBRX_RST_ZERO;
      flags_upper_reg <= `UBRX_RST_FLAGS_UPPER;
    end else if (clk_en_i) begin
      if (wr_stat) begin
        port_enable_reg <= bus.wdata[`UBRX_BIT_PORT_EN];
        nine_bit_select_reg <= bus.wdata[`UBRX_BIT_NINE_SEL];
        single_receive_enable_reg <= bus.wdata[`UBRX_BIT_SINGLE_EN];
        continuous_receive_enable_reg <= bus.wdata[`UBRX_BIT_CONT_EN];
      end else if (bus.wr && bus.addr == `UBRX_ADDR_XMT_STAT) begin
        xmt_stat_reg <= bus.wdata;
      end else if (wr_div) begin
        baud_divisor_reg <= bus.wdata;
      end else if (bus.wr && bus.addr == `UBRX_ADDR_INT_ENABLES) begin
        receive_int_enable_reg <= bus.wdata[`UBRX_BIT_RCV_IE];
        int_enables_upper_reg <= bus.wdata;
      end else if (bus.wr && bus.addr == `UBRX_ADDR_PERIPH_FLAGS) begin
        flags_upper_reg <= bus.wdata[7:1]; // receive flag bit is not writable
      end
    end
  end

  logic sync_mode;
  logic sync_master;
  logic rx_run;
  logic rx_reset;
  assign sync_mode = xmt_stat_reg[`UBRX_BIT_SYNC];
  assign sync_master = xmt_stat_reg[`UBRX_BIT_MASTER];
  assign rx_run = port_enable_reg && !sync_mode && continuous_receive_enable_reg;
  assign rx_reset = !port_enable_reg ||
                    (!single_receive_enable_reg && !continuous_receive_enable_reg);

  // ----------------------------------------------------------------
  // baud generator: prescaler then 8-bit reload timer
  // ----------------------------------------------------------------
  logic [5:0] prescale_reg;
  logic [7:0] baud_timer_reg;
  logic ovs_tick;
  logic gen_active;
  logic [5:0] prescale_last;
  assign gen_active = !sync_mode || sync_master;
  assign prescale_last = sync_mode ? `UBRX_SYNC_PRESCALE : `UBRX_ASYNC_PRESCALE;
  assign ovs_tick = gen_active && (prescale_reg == prescale_last) &&
                    (baud_timer_reg == `UBRX_RST_ZERO);

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prescale_reg <= 6'h00;
    end else if (clk_en_i) begin
      if (wr_div || !gen_active || prescale_reg == prescale_last) begin
        prescale_reg <= 6'h00;
      end else begin
        prescale_reg <= prescale_reg + 6'h01;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      baud_timer_reg <= `UBRX_RST_ZERO;
    end else if (clk_en_i) begin
      if (wr_div) begin
        baud_timer_reg <= bus.wdata; // loaded count restarts a full period
      end else if (gen_active && prescale_reg == prescale_last) begin
        if (baud_timer_reg == `UBRX_RST_ZERO) begin
          baud_timer_reg <= baud_divisor_reg; // free-running reload
        end else begin
          baud_timer_reg <= baud_timer_reg - 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // oversampling front end and majority vote
  // ----------------------------------------------------------------
  logic [3:0] ovs_phase_reg;
  logic [2:0] samples_reg;
  logic vote;
  assign vote = (samples_reg[0] & samples_reg[1]) | (samples_reg[1] & samples_reg[2]) |
                (samples_reg[0] & samples_reg[2]);

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      samples_reg <= 3'b111;
    end else if (clk_en_i && ovs_tick) begin
      if (ovs_phase_reg == `UBRX_VOTE_FIRST || ovs_phase_reg == `UBRX_VOTE_MID ||
          ovs_phase_reg == `UBRX_VOTE_LAST) begin
        samples_reg <= {samples_reg[1:0], pin_sync_reg};
      end
    end
  end

  // ----------------------------------------------------------------
  // receive state machine and shift register
  // ----------------------------------------------------------------
  ubrx_state_e state_reg;
  logic [8:0] receive_shift_register_reg;
  logic [3:0] bit_cnt_reg;
  logic bit_done;
  logic char_done;
  logic stop_ok;
  assign bit_done = ovs_tick && (ovs_phase_reg == `UBRX_OVS_LAST);
  assign char_done = bit_done && (state_reg == UBRX_STOP);
  assign stop_ok = vote;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ovs_phase_reg <= 4'h0;
    end else if (clk_en_i) begin
      if (rx_reset) begin
        ovs_phase_reg <= 4'h0;
      end else if (state_reg == UBRX_IDLE && rx_run && ovs_tick && !pin_sync_reg) begin
        ovs_phase_reg <= 4'h1; // start edge aligns the phase
      end else if (ovs_tick) begin
        ovs_phase_reg <= ovs_phase_reg + 4'h1; // wraps every sixteen ticks
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= UBRX_IDLE;
      bit_cnt_reg <= 4'h0;
      receive_shift_register_reg <= 9'h000;
    end else if (clk_en_i) begin
      if (rx_reset || !rx_run) begin
        state_reg <= UBRX_IDLE;
        bit_cnt_reg <= 4'h0;
      end else begin
        case (state_reg)
          UBRX_IDLE: begin
            if (ovs_tick && !pin_sync_reg) begin
              state_reg <= UBRX_START;
            end
          end
          UBRX_START: begin
            if (bit_done) begin
              state_reg <= vote ? UBRX_IDLE : UBRX_DATA; // false start rejected
              bit_cnt_reg <= 4'h0;
            end
          end
          UBRX_DATA: begin
            if (bit_done) begin
              receive_shift_register_reg <= {vote, receive_shift_register_reg[8:1]};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (bit_cnt_reg + 4'h1 ==
                  (nine_bit_select_reg ? `UBRX_NINE_BITS : `UBRX_DATA_BITS)) begin
                state_reg <= UBRX_STOP;
              end
            end
          end
          UBRX_STOP: begin
            if (bit_done) begin
              state_reg <= UBRX_IDLE;
            end
          end
          default: state_reg <= UBRX_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // character FIFO and overrun
  // ----------------------------------------------------------------
  ubrx_char_s fifo_mem [0:1];
  ubrx_char_s new_char;
  logic rd_ptr_reg;
  logic wr_ptr_reg;
  logic [1:0] count_reg;
  logic overrun_flag_reg;
  logic push;
  logic pop;
  logic fifo_full;

  // nine-bit chars are LSB first, eight-bit ones sit one place higher
  assign new_char.data = nine_bit_select_reg ? receive_shift_register_reg[7:0] :
                                               receive_shift_register_reg[8:1];
  assign new_char.ninth = nine_bit_select_reg & receive_shift_register_reg[8];
  assign new_char.frame_err = !stop_ok;
  assign fifo_full = count_reg[1];
  assign push = char_done && !fifo_full && !overrun_flag_reg;
  assign pop = bus.rd && (bus.addr == `UBRX_ADDR_RCV_BYTE) && (count_reg != 2'b00);

  always_ff @(posedge mclk_i) begin
    if (clk_en_i && push) begin
      fifo_mem[wr_ptr_reg] <= new_char;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      count_reg <= 2'b00;
    end else if (clk_en_i) begin
      if (rx_reset) begin
        rd_ptr_reg <= 1'b0;
        wr_ptr_reg <= 1'b0;
        count_reg <= 2'b00;
      end else begin
        if (push) begin
          wr_ptr_reg <= !wr_ptr_reg;
        end
        if (pop) begin
          rd_ptr_reg <= !rd_ptr_reg; // arrival order
        end
        if (push && !pop) begin
          count_reg <= count_reg + 2'b01;
        end else if (pop && !push) begin
          count_reg <= count_reg - 2'b01;
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      overrun_flag_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (char_done && fifo_full) begin
        overrun_flag_reg <= 1'b1; // char dropped
      end else if (rx_reset) begin
        overrun_flag_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // status, interrupt and read data
  // ----------------------------------------------------------------
  ubrx_char_s head;
  logic receive_int_flag;
  assign head = fifo_mem[rd_ptr_reg];
  assign receive_int_flag = (count_reg != 2'b00); // clears when FIFO empties

  logic [7:0] stat_view;
  logic [7:0] flags_view;
  logic [7:0] ie_view;
  always_comb begin
    stat_view = `UBRX_RST_ZERO;
    stat_view[`UBRX_BIT_PORT_EN] = port_enable_reg;
    stat_view[`UBRX_BIT_NINE_SEL] = nine_bit_select_reg;
    stat_view[`UBRX_BIT_SINGLE_EN] = single_receive_enable_reg;
    stat_view[`UBRX_BIT_CONT_EN] = continuous_receive_enable_reg;
    stat_view[`UBRX_BIT_OVERRUN] = overrun_flag_reg;
    stat_view[`UBRX_BIT_FRAME_ERR] = receive_int_flag & head.frame_err;
    stat_view[`UBRX_BIT_NINTH] = receive_int_flag & head.ninth;
    flags_view = {flags_upper_reg, receive_int_flag};
    ie_view = {int_enables_upper_reg[7:1], receive_int_enable_reg};
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rcv_irq_o <= 1'b0;
    end else if (clk_en_i) begin
      rcv_irq_o <= receive_int_flag && receive_int_enable_reg;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= `UBRX_RST_ZERO;
    end else if (clk_en_i) begin
      if (!bus.rd) begin
        reg_rdata_o <= `UBRX_RST_ZERO;
      end else if (bus.addr == `UBRX_ADDR_RCV_STAT) begin
        reg_rdata_o <= stat_view;
      end else if (bus.addr == `UBRX_ADDR_RCV_BYTE) begin
        reg_rdata_o <= receive_int_flag ? head.data : `UBRX_RST_ZERO;
      end else if (bus.addr == `UBRX_ADDR_XMT_STAT) begin
        reg_rdata_o <= xmt_stat_reg;
      end else if (bus.addr == `UBRX_ADDR_PERIPH_FLAGS) begin
        reg_rdata_o <= flags_view;
      end else if (bus.addr == `UBRX_ADDR_DIVISOR) begin
        reg_rdata_o <= baud_divisor_reg;
      end else if (bus.addr == `UBRX_ADDR_INT_ENABLES) begin
        reg_rdata_o <= ie_view;
      end else begin
        reg_rdata_o <= `UBRX_RST_ZERO;
      end
    end
  end

endmodule : ubrx_receiver

// File: tb/ubrx_receiver_asserts.sv
/*
 * Checker on the receiver's register port and interrupt request.
 * Assumes a bind to ubrx_receiver; one clock, async active-low reset.
 */
`timescale 1ns/1ns

module ubrx_receiver_asserts (
  input wire logic mclk_i, // clock
  input wire logic resetn_i, // reset, active low
  input wire logic clk_en_i, // clock enable
  input wire logic [7:0] reg_addr_i, // address
  input wire logic [7:0] reg_wdata_i, // write data
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  input wire logic [7:0] reg_rdata_o, // read data
  input wire logic receive_line_pin_i, // serial line
  input wire logic rcv_irq_o // interrupt request
);
  // ------------------------------
  // shadow of software state
  // ------------------------------
  logic [3:0] ctl_q;
  logic [7:0] div_q;
  logic ie_q;
  logic rd_q;
  logic [7:0] ra_q;
  logic ovr_q;
  logic halt_w;
  logic wr_w;

  assign wr_w = reg_wr_i && clk_en_i;
  // receive logic held in reset
  assign halt_w = !ctl_q[3] || !(ctl_q[1] || ctl_q[0]);

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_q <= 4'h0;
      div_q <= 8'h00;
      ie_q <= 1'b0;
    end else begin
      if (wr_w && reg_addr_i == 8'h13) ctl_q <= reg_wdata_i[7:4];
      if (wr_w && reg_addr_i == 8'h17) div_q <= reg_wdata_i;
      if (wr_w && reg_addr_i == 8'h18) ie_q <= reg_wdata_i[0];
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_q <= 1'b0;
      ra_q <= 8'h00;
    end else if (clk_en_i) begin
      rd_q <= reg_rd_i;
      ra_q <= reg_addr_i;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) ovr_q <= 1'b0;
    else if (halt_w) ovr_q <= 1'b0;
    else if (rd_q && ra_q == 8'h13 && reg_rdata_o[1]) ovr_q <= 1'b1;
  end

  // ------------------------------
  // properties
  // ------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  property p_ctl_rb;
    rd_q && ra_q == 8'h13 |-> reg_rdata_o[7:4] == ctl_q;
  endproperty
  a_ctl_rb: assert property (p_ctl_rb) else $error("control bits wrong");
  property p_div_rb;
    rd_q && ra_q == 8'h17 |-> reg_rdata_o == div_q;
  endproperty
  a_div_rb: assert property (p_div_rb) else $error("divisor wrong");
  property p_ie_rb;
    rd_q && ra_q == 8'h18 |-> reg_rdata_o[0] == ie_q;
  endproperty
  a_ie_rb: assert property (p_ie_rb) else $error("enable bit wrong");
  property p_ie_gate;
    (!ie_q) [*2] |-> !rcv_irq_o;
  endproperty
  a_ie_gate: assert property (p_ie_gate) else $error("request while disabled");
  property p_flag_irq;
    rd_q && ra_q == 8'h16 && $past(ie_q) |-> reg_rdata_o[0] == rcv_irq_o;
  endproperty
  a_flag_irq: assert property (p_flag_irq) else $error("flag and request differ");
  property p_halt;
    halt_w [*4] |-> !rcv_irq_o;
  endproperty
  a_halt: assert property (p_halt) else $error("request while halted");
  property p_ovr_hold;
    rd_q && ra_q == 8'h13 && ovr_q |-> reg_rdata_o[1];
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("overrun cleared alone");
  property p_ovr_clr;
    (halt_w [*3]) ##0 (rd_q && ra_q == 8'h13) |-> !reg_rdata_o[1];
  endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("overrun kept in reset");
endmodule : ubrx_receiver_asserts

// File: tb/ubrx_line_model.sv
/*
 * Remote asynchronous transmitter driving the receive line.
 * Assumes the bench calls send from one process, clocked by mclk_i.
 */
`timescale 1ns/1ns

module ubrx_line_model (
  input wire logic mclk_i, // clock
  output logic line_o // serial line, idles high
);
  initial line_o = 1'b1;

  // start, data lsb first, optional ninth, stop, then one idle bit
  task automatic send(input logic [8:0] v, input logic nine, input logic stop_hi,
                      input logic glitch, input int bclk);
    logic [11:0] f;
    int n;
    f = nine ? {1'b1, stop_hi, v, 1'b0} : {2'b11, stop_hi, v[7:0], 1'b0};
    n = nine ? 12 : 11;
    for (int b = 0; b < n; b++) begin
      for (int c = 0; c < bclk; c++) begin
        @(posedge mclk_i);
        // at bclk 64 the four-clock glitch covers exactly one of the three votes
        line_o <= f[b] ^ (glitch && b == 1 && c >= bclk / 2 - 4 && c < bclk / 2);
      end
    end
  endtask : send
endmodule : ubrx_line_model

// File: tb/test_ubrx_receiver.sv
/*
 * Self-checking bench for the baud generator and receiver.
 * Assumes the package, line model and checker are compiled first.
 */
`timescale 1ns/1ns

module test_ubrx_receiver;
  logic mclk_i;
  logic resetn_i;
  logic clk_en_i;
  logic [7:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [7:0] reg_rdata_o;
  logic line;
  logic rcv_irq_o;
  int comparisons;
  int miscompares;

  ubrx_receiver uut (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .clk_en_i(clk_en_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .receive_line_pin_i(line),
    .rcv_irq_o(rcv_irq_o)
  );
  ubrx_line_model tx (.mclk_i(mclk_i), .line_o(line));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // ------------------------------
  // bus and check tasks
  // ------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(negedge mclk_i);
    chk(reg_rdata_o, exp);
  endtask : rdc

  task automatic results();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_reset_values();
    rdc(8'h16, 8'h02);
    rdc(8'h15, 8'h02);
    rdc(8'h13, 8'h00);
    rdc(8'h18, 8'h00);
    rdc(8'h20, 8'h00);
    wr(8'h16, 8'hFF);
    rdc(8'h16, 8'hFE);
    wr(8'h16, 8'h02);
    clk_en_i <= 1'b0;
    wr(8'h17, 8'h55);
    clk_en_i <= 1'b1;
    rdc(8'h17, 8'h00);
    wr(8'h14, 8'h77);
    rdc(8'h14, 8'h00);
    wr(8'h17, 8'h00);
    wr(8'h15, 8'h00);
    wr(8'h18, 8'h01);
    wr(8'h13, 8'h90);
  endtask : t_reset_values

  task automatic t_single();
    int n;
    tx.send(9'h0A5, 1'b0, 1'b1, 1'b1, 64);
    n = 0;
    while (rcv_irq_o !== 1'b1 && n < 2000) begin
      @(negedge mclk_i);
      n++;
    end
    chk(8'(n == 2000), 8'h00);
    if (n == 2000) begin
      results();
    end
    rdc(8'h16, 8'h03);
    rdc(8'h13, 8'h90);
    rdc(8'h14, 8'hA5);
    rdc(8'h16, 8'h02);
    chk({7'h00, rcv_irq_o}, 8'h00);
  endtask : t_single

  task automatic t_overrun();
    tx.send(9'h011, 1'b0, 1'b1, 1'b0, 64);
    tx.send(9'h022, 1'b0, 1'b1, 1'b0, 64);
    tx.send(9'h033, 1'b0, 1'b1, 1'b0, 64);
    rdc(8'h13, 8'h92);
    rdc(8'h14, 8'h11);
    rdc(8'h14, 8'h22);
    rdc(8'h14, 8'h00);
    tx.send(9'h044, 1'b0, 1'b1, 1'b0, 64);
    rdc(8'h16, 8'h02);
    rdc(8'h13, 8'h92);
    wr(8'h13, 8'h80);
    wr(8'h13, 8'h90);
    rdc(8'h13, 8'h90);
    tx.send(9'h055, 1'b0, 1'b1, 1'b0, 64);
    rdc(8'h14, 8'h55);
  endtask : t_overrun

  task automatic t_frame_nine();
    wr(8'h13, 8'hD0);
    tx.send(9'h15A, 1'b1, 1'b0, 1'b0, 64);
    tx.send(9'h0C3, 1'b1, 1'b1, 1'b0, 64);
    rdc(8'h13, 8'hD5);
    rdc(8'h14, 8'h5A);
    rdc(8'h13, 8'hD0);
    rdc(8'h14, 8'hC3);
    wr(8'h13, 8'h90);
  endtask : t_frame_nine

  task automatic t_rate();
    wr(8'h17, 8'h02);
    tx.send(9'h03C, 1'b0, 1'b1, 1'b0, 192);
    rdc(8'h14, 8'h3C);
    wr(8'h15, 8'h10);
    tx.send(9'h066, 1'b0, 1'b1, 1'b0, 192);
    rdc(8'h16, 8'h02);
    wr(8'h15, 8'h00);
    wr(8'h17, 8'h00);
  endtask : t_rate

  task automatic t_gating();
    wr(8'h13, 8'h80);
    tx.send(9'h077, 1'b0, 1'b1, 1'b0, 64);
    rdc(8'h16, 8'h02);
    wr(8'h13, 8'h90);
    wr(8'h18, 8'h00);
    tx.send(9'h078, 1'b0, 1'b1, 1'b0, 64);
    rdc(8'h16, 8'h03);
    chk({7'h00, rcv_irq_o}, 8'h00);
    wr(8'h18, 8'h01);
    @(negedge mclk_i);
    @(negedge mclk_i);
    chk({7'h00, rcv_irq_o}, 8'h01);
    wr(8'h13, 8'h00);
    rdc(8'h13, 8'h00);
    rdc(8'h16, 8'h02);
    rdc(8'h14, 8'h00);
  endtask : t_gating

  initial begin
    resetn_i = 1'b0;
    clk_en_i = 1'b1;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    comparisons = 0;
    miscompares = 0;
    repeat (5) @(posedge mclk_i);
    resetn_i <= 1'b1;
    t_reset_values();
    t_single();
    t_overrun();
    t_frame_nine();
    t_rate();
    t_gating();
    results();
  end
endmodule : test_ubrx_receiver

bind ubrx_receiver ubrx_receiver_asserts u_chk (
  .mclk_i(mclk_i),
  .resetn_i(resetn_i),
  .clk_en_i(clk_en_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .receive_line_pin_i(receive_line_pin_i),
  .rcv_irq_o(rcv_irq_o)
);
